//--- core/sac_ctrl.sv
/*
  sac_ctrl: successive-approximation converter and comparator control.
  assumes core strobes are one-cycle pulses on mclk, mcyc_en marks each
  machine cycle, and cmp_above (input above reference) comes from the pin side.
*/
// Added by the designer: the plain strobed port and the address map.
module sac_ctrl
  import sac_pkg::*;
#(
  parameter int CONV_MCYC = SAC_CONV_MCYC,
  parameter int CMP_MCYC = SAC_CMP_MCYC
)
(
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic mcyc_en,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // core instructions
  input wire sac_op_t op,
  input wire sac_acc_t acc_in,
  output sac_acc_t acc_out,
  output logic acc_valid,
  output logic skip,
  output logic irq_req,
  // analog side
  input wire logic cmp_above,
  output logic [9:0] dac_code,
  output logic [1:0] ain_sel,
  output logic busy
);
  localparam int CW = 6;
  localparam logic [CW-1:0] CONV_LAST = CW'(CONV_MCYC - 1);
  localparam logic [CW-1:0] CMP_LAST = CW'(CMP_MCYC - 1);
  localparam logic [2:0] PHASE_LAST = 3'(SAC_BIT_MCYC - 1);
  // no decisions after the tenth bit; the tail cycles only settle
  localparam logic [CW-1:0] DECIDE_END = CW'(SAC_RES_W * SAC_BIT_MCYC);

  sac_state_t state_r;
  logic [3:0] ctrl_r;
  logic [3:0] irq2_r;
  logic [7:0] cmpv_r;
  logic [9:0] res_r;
  logic [9:0] trial_r;
  logic [CW-1:0] cnt_r;
  logic flag_r;
  logic above_s;
  logic cmp_mode;
  logic done_conv;
  logic done_cmp;
  logic flag_clr;
  logic [3:0] bitpos_r;
  logic [2:0] phase_r;

  function automatic logic [9:0] onehot10(input logic [3:0] p);
    onehot10 = 10'h001 << p;
  endfunction

  sac_sync u_sync
  (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .d(cmp_above),
    .q(above_s)
  );

  assign cmp_mode = ctrl_r[SAC_CTRL_MODE_BIT];
  assign done_conv = (state_r == SAC_CONV) && mcyc_en && (cnt_r == CONV_LAST);
  assign done_cmp = (state_r == SAC_CMP) && mcyc_en && (cnt_r == CMP_LAST);
  // skip and interrupt acknowledge both consume the flag
  assign flag_clr = (op.skip_test && flag_r && !irq2_r[SAC_IRQ2_ADIE_BIT])
    || (op.irq_ack && irq_req);

  // control register; mode must stay put while busy, software's duty
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      ctrl_r <= SAC_CTRL_RST;
    else if (ce && reg_wr && reg_addr == SAC_OFF_CTRL)
      ctrl_r <= reg_wdata[3:0];
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      irq2_r <= SAC_IRQ2_RST;
    else if (ce && reg_wr && reg_addr == SAC_OFF_IRQ2)
      irq2_r <= reg_wdata[3:0];
  end

  // compare value, only reachable in comparator mode
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      cmpv_r <= SAC_CMPV_RST;
    else if (ce && cmp_mode)
    begin
      if (op.load_cmp)
        cmpv_r <= {acc_in.b, acc_in.a};
      else if (reg_wr && reg_addr == SAC_OFF_CMPV)
        cmpv_r <= reg_wdata;
    end
  end

  // sequencer
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= SAC_IDLE;
      cnt_r <= '0;
    end
    else if (ce)
    begin
      case (state_r)
        SAC_IDLE:
        begin
          cnt_r <= '0;
          if (op.start)
            state_r <= cmp_mode ? SAC_CMP : SAC_CONV;
        end
        SAC_CONV, SAC_CMP:
        begin
          // a start here is not looked at
          if (done_conv || done_cmp)
            state_r <= SAC_IDLE;
          else if (mcyc_en)
            cnt_r <= cnt_r + CW'(1);
        end
        default:
          state_r <= SAC_IDLE;
      endcase
    end
  end

  // successive approximation: one bit per six machine cycles, msb first
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      res_r <= SAC_RES_RST;
      trial_r <= SAC_RES_RST;
      bitpos_r <= 4'h9;
      phase_r <= 3'h0;
    end
    else if (ce)
    begin
      if (state_r == SAC_IDLE && op.start && !cmp_mode)
      begin
        trial_r <= onehot10(4'h9);
        bitpos_r <= 4'h9;
        phase_r <= 3'h0;
      end
      else if (state_r == SAC_CONV && mcyc_en)
      begin
        // six cycles per bit leave room for dac and synchroniser latency
        phase_r <= (phase_r == PHASE_LAST) ? 3'h0 : phase_r + 3'h1;
        if (phase_r == PHASE_LAST && cnt_r < DECIDE_END)
        begin
          // decision: keep bit when reference below input
          if (!above_s)
            trial_r[bitpos_r] <= 1'b0;
          if (bitpos_r != 4'h0)
          begin
            trial_r[bitpos_r - 4'h1] <= 1'b1;
            bitpos_r <= bitpos_r - 4'h1;
          end
        end
      end
      if (done_conv)
        res_r <= trial_r;
      else if (state_r == SAC_CMP)
        res_r <= trial_r; // contents not defined in this mode
    end
  end

  // done flag: hardware set wins over clear
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      flag_r <= 1'b0;
    else if (ce)
    begin
      if (done_conv || (done_cmp && !above_s))
        flag_r <= 1'b1;
      else if (flag_clr)
        flag_r <= 1'b0;
    end
  end

  // instruction answers
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      acc_out <= '0;
      acc_valid <= 1'b0;
      skip <= 1'b0;
      irq_req <= 1'b0;
    end
    else if (ce)
    begin
      acc_valid <= op.move_lo || op.move_hi;
      skip <= op.skip_test && flag_r && !irq2_r[SAC_IRQ2_ADIE_BIT];
      irq_req <= flag_r && irq2_r[SAC_IRQ2_ADIE_BIT] && !flag_clr;
      if (op.move_lo)
        acc_out <= {4'h0, res_r[1:0], 2'b00};
      else if (op.move_hi)
        acc_out <= {res_r[9:6], res_r[5:2]};
    end
  end

  // reference code: 10-bit trial or compare value scaled from /256 to /1024
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      dac_code <= SAC_RES_RST;
      ain_sel <= 2'b00;
      busy <= 1'b0;
    end
    else if (ce)
    begin
      dac_code <= cmp_mode ? {cmpv_r, 2'b00} : trial_r;
      ain_sel <= ctrl_r[1:0];
      busy <= state_r != SAC_IDLE;
    end
  end

  // register reads; compare value hidden outside comparator mode
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else if (ce)
    begin
      reg_rdata <= 8'h00;
      if (reg_rd)
      begin
        case (reg_addr)
          SAC_OFF_CTRL: reg_rdata <= {4'h0, ctrl_r};
          SAC_OFF_IRQ2: reg_rdata <= {4'h0, irq2_r};
          SAC_OFF_STATUS: reg_rdata <= {6'h00, state_r != SAC_IDLE, flag_r};
          SAC_OFF_CMPV: reg_rdata <= cmp_mode ? cmpv_r : 8'h00;
          SAC_OFF_RES_HI: reg_rdata <= res_r[9:2];
          SAC_OFF_RES_LO: reg_rdata <= {6'h00, res_r[1:0]};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

//--- core/sac_sync.sv
/*
  sac_sync: two-flop synchroniser for the comparator outcome.
  assumes the analog comparator output is asynchronous to mclk.
*/
module sac_sync
  import sac_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // level
  input wire logic d,
  output logic q
);
  logic meta_r;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end
    else if (ce)
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

//--- pkg/sac_pkg.sv
/*
  sac_pkg: constants and carrier types for the converter/comparator control.
  assumes one clock at 100 MHz; machine cycle given by an enable from the core.
*/
package sac_pkg;
  // register bus offsets
  localparam logic [3:0] SAC_OFF_CTRL = 4'h0;
  localparam logic [3:0] SAC_OFF_IRQ2 = 4'h1;
  localparam logic [3:0] SAC_OFF_STATUS = 4'h2;
  localparam logic [3:0] SAC_OFF_CMPV = 4'h3;
  localparam logic [3:0] SAC_OFF_RES_HI = 4'h4;
  localparam logic [3:0] SAC_OFF_RES_LO = 4'h5;
  // field positions
  localparam int SAC_CTRL_MODE_BIT = 3;
  localparam int SAC_IRQ2_ADIE_BIT = 2;
  // reset values
  localparam logic [3:0] SAC_CTRL_RST = 4'h0;
  localparam logic [3:0] SAC_IRQ2_RST = 4'h0;
  localparam logic [7:0] SAC_CMPV_RST = 8'h00;
  localparam logic [9:0] SAC_RES_RST = 10'h000;
  // timing in machine cycles, and result width in bits
  localparam int SAC_CONV_MCYC = 62;
  localparam int SAC_CMP_MCYC = 8;
  localparam int SAC_BIT_MCYC = 6;
  localparam int SAC_RES_W = 10;

  typedef enum logic [1:0]
  {
    SAC_IDLE = 2'b00,
    SAC_CONV = 2'b01,
    SAC_CMP = 2'b10
  } sac_state_t;

  // core instruction strobes
  typedef struct packed
  {
    logic start;
    logic skip_test;
    logic load_cmp;
    logic move_lo;
    logic move_hi;
    logic irq_ack;
  } sac_op_t;

  // accumulator pair
  typedef struct packed
  {
    logic [3:0] b;
    logic [3:0] a;
  } sac_acc_t;
endpackage

//--- testbench/sac_analog_model.sv
/*
  sac_analog_model: analog pin and comparator seen from the converter.
  assumes the input is given in half-lsb steps of the 10-bit scale.
*/
module sac_analog_model
(
  // reference and input
  input wire logic [9:0] dac_code,
  input wire logic [10:0] vin_half,
  // outcome
  output logic cmp_above
);
  timeunit 1ns;
  timeprecision 1ps;
  // odd half-lsb inputs never tie with a reference step
  assign cmp_above = ({dac_code, 1'b0} < vin_half);
endmodule

//--- testbench/sac_ctrl_checker.sv
/*
  sac_ctrl_checker: port assertions for sac_ctrl.
  assumes the bench holds mcyc_en high and drops ce only briefly.
*/
module sac_ctrl_checker
  import sac_pkg::*;
#(
  parameter int CONV_MCYC = SAC_CONV_MCYC,
  parameter int CMP_MCYC = SAC_CMP_MCYC
)
(
  // clock and register port
  input wire logic mclk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  // core side
  input wire sac_op_t op,
  input wire sac_acc_t acc_out,
  input wire logic acc_valid,
  input wire logic skip,
  input wire logic irq_req,
  // analog side
  input wire logic [1:0] ain_sel,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  a_skip_cause: assert property (skip |-> $past(op.skip_test))
    else $error("skip without test");
  a_irq_holds: assert property (irq_req && !op.irq_ack && !$past(op.irq_ack) && !reg_wr
    && !$past(reg_wr) |=> irq_req) else $error("irq dropped");
  a_ack_clears: assert property (irq_req && op.irq_ack && !busy |-> ##[1:2] !irq_req)
    else $error("irq kept after ack");
  a_busy_min: assert property ($rose(busy) |=> busy[*6])
    else $error("operation too short");
  a_busy_max: assert property ($rose(busy) |-> ##[6:70] !busy)
    else $error("operation too long");
  a_start_busy: assert property (op.start && !busy |-> ##2 busy)
    else $error("start not taken");
  a_lo_zero: assert property (op.move_lo |=> acc_valid && acc_out.a[1:0] == 2'b00)
    else $error("low move shape");
  a_hi_valid: assert property (op.move_hi |=> acc_valid)
    else $error("high move missing");
  a_ain_follow: assert property (reg_wr && reg_addr == SAC_OFF_CTRL
    |=> ##1 ain_sel == $past(reg_wdata[1:0], 2)) else $error("input select");
endmodule
bind sac_ctrl sac_ctrl_checker #(.CONV_MCYC(CONV_MCYC), .CMP_MCYC(CMP_MCYC)) chk_u (.mclk,
  .rstn, .reg_wr, .reg_addr, .reg_wdata, .op, .acc_out, .acc_valid, .skip, .irq_req,
  .ain_sel, .busy);

//--- testbench/tb.sv
/*
  tb: register and instruction sequences for sac_ctrl.
  assumes the analog model answers at once; mcyc_en held high, ce dropped once.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sac_pkg::*;
  logic ce = 1'b1;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, rd_val;
  sac_op_t op = '0;
  sac_acc_t acc_in = '0;
  sac_acc_t acc_out;
  logic acc_valid, skip, irq_req, cmp_above, busy;
  logic [9:0] dac_code;
  logic [1:0] ain_sel;
  logic [10:0] vin_half = 11'h000;
  int num_errors = 0;
  int cmp_count = 0;
  always #5 mclk = ~mclk;
  sac_ctrl dut_u (.mclk, .rstn, .ce, .mcyc_en(1'b1), .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .op, .acc_in, .acc_out, .acc_valid, .skip, .irq_req, .cmp_above,
    .dac_code, .ain_sel, .busy);
  sac_analog_model ana_u (.dac_code, .vin_half, .cmp_above);
  task chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask
  task pulse(input logic [5:0] o);
    @(posedge mclk);
    op <= sac_op_t'(o);
    @(posedge mclk);
    op <= '0;
    #1;
  endtask
  // bounded wait, steps stay clear of the clock edge
  task wait_idle;
    // busy follows the start by two edges
    repeat (2) @(posedge mclk);
    #1;
    for (int i = 0; i < 200 && busy !== 1'b0; i++) #10;
    chk("busy", 10'h000, {9'h000, busy});
  endtask
  task complete_run;
    if (num_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    for (int a = 0; a < 3; a++)
    begin
      rd(a[3:0]);
      chk("reset reg", 10'h000, {2'b00, rd_val});
    end
    rd(4'hF);
    chk("unmapped", 10'h000, {2'b00, rd_val});
    // conversion of 301 with a second start mid-run
    vin_half <= 11'h25B;
    wr(SAC_OFF_CTRL, 8'h01);
    pulse(6'h20);
    chk("ain_sel", 10'h001, {8'h00, ain_sel});
    repeat (10) @(posedge mclk);
    // frozen cycles must not disturb the running conversion
    ce <= 1'b0;
    repeat (5) @(posedge mclk);
    ce <= 1'b1;
    pulse(6'h20);
    wait_idle;
    rd(SAC_OFF_STATUS);
    chk("status", 10'h001, {2'b00, rd_val});
    pulse(6'h10);
    chk("skip", 10'h001, {9'h000, skip});
    pulse(6'h10);
    chk("skip again", 10'h000, {9'h000, skip});
    pulse(6'h04);
    chk("acc lo", 10'h004, {2'b00, acc_out});
    pulse(6'h02);
    chk("acc hi", 10'h04B, {2'b00, acc_out});
    // comparator against 0x9A
    wr(SAC_OFF_CTRL, 8'h08);
    acc_in <= sac_acc_t'(8'h9A);
    pulse(6'h08);
    rd(SAC_OFF_CMPV);
    chk("cmpv", 10'h09A, {2'b00, rd_val});
    chk("dac", 10'h268, dac_code);
    for (int i = 0; i < 2; i++)
    begin
      vin_half <= i ? 11'h25B : 11'h579;
      pulse(6'h20);
      wait_idle;
      rd(SAC_OFF_STATUS);
      chk("cmp flag", i[9:0], {2'b00, rd_val});
    end
    wr(SAC_OFF_IRQ2, 8'h04);
    @(posedge mclk);
    #1;
    chk("irq", 10'h001, {9'h000, irq_req});
    pulse(6'h10);
    chk("no skip", 10'h000, {9'h000, skip});
    pulse(6'h01);
    @(posedge mclk);
    #1;
    chk("irq ack", 10'h000, {9'h000, irq_req});
    wr(SAC_OFF_IRQ2, 8'h00);
    wr(SAC_OFF_CTRL, 8'h00);
    pulse(6'h10);
    rd(SAC_OFF_CMPV);
    chk("cmpv hidden", 10'h000, {2'b00, rd_val});
    wr(SAC_OFF_CTRL, 8'h08);
    rd(SAC_OFF_CMPV);
    chk("cmpv kept", 10'h09A, {2'b00, rd_val});
    complete_run;
  end
  initial
  begin
    #20000;
    num_errors++;
    complete_run;
  end
endmodule
